// *** rtl/atg_ctrl.sv ***
// converter control block: control register b, input disables, trigger and result shaping
module atg_ctrl #(
    parameter int unsigned PIN_N = 11
) (
    // clock and reset
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst,
    // register port
    input  wire logic [atg_pkg::ADDR_W-1:0]     i_addr,
    input  wire logic [atg_pkg::DATA_W-1:0]     i_wdata,
    input  wire logic                           i_wr,
    input  wire logic                           i_rd,
    output logic      [atg_pkg::DATA_W-1:0]     o_rdata,
    // converter core
    input  wire logic [7:0]                     i_trig_flags,
    input  wire logic                           i_conv_done,
    input  wire logic [9:0]                     i_raw_mag,
    input  wire logic                           i_raw_neg,
    input  wire logic [2:0]                     i_gain_base,
    output logic                                o_conv_start,
    output atg_pkg::atg_core_cfg_t              o_core_cfg,
    output logic      [9:0]                     o_result,
    output logic                                o_result_valid,
    // pins
    input  wire logic [PIN_N-1:0]               i_pin,
    output logic      [PIN_N-1:0]               o_pin_rd,
    output logic      [PIN_N-1:0]               o_buf_off,
    output logic                                o_refpin_off
);

    // register state
    logic [7:0] ctlb_r,  ctlb_nxt;
    logic [7:0] dis0_r,  dis0_nxt;
    logic [7:0] dis1_r,  dis1_nxt;
    logic [7:0] ctla_r,  ctla_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // conversion tracking
    logic                   busy_r,      busy_nxt;
    logic                   chan_msb_r,  chan_msb_nxt;
    atg_pkg::atg_core_cfg_t cfg_r,       cfg_nxt;
    logic [9:0]             result_r,    result_nxt;
    logic                   res_vld_r,   res_vld_nxt;

    logic                   trig_start;
    logic                   sw_start;
    logic                   start_r,     start_nxt;
    logic [PIN_N-1:0]       pin_dis;
    logic [PIN_N-1:0]       pin_rd;
    logic [PIN_N-1:0]       buf_off;
    logic                   wr_hit_a;

    // channel 6..0 disables sit in bits 7:4,2:0; channels 10..7 in dis1 7:4
    assign pin_dis = {dis1_r[7:4], dis0_r[7:4], dis0_r[2:0]};

    atg_trig_sel #(
        .SRC_N (8)
    ) u_trig (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_src     (ctlb_r[2:0]),
        .i_auto_en (ctla_r[atg_pkg::BIT_AUTO_EN]),
        .i_conv_en (ctla_r[atg_pkg::BIT_CONV_EN]),
        .i_flags   (i_trig_flags),
        .o_start   (trig_start)
    );

    atg_pin_gate #(
        .PIN_N (PIN_N)
    ) u_pins (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     (i_pin),
        .i_disable (pin_dis),
        .o_pin_rd  (pin_rd),
        .o_buf_off (buf_off)
    );

    // register writes
    always_comb begin
        ctlb_nxt = ctlb_r;
        dis0_nxt = dis0_r;
        dis1_nxt = dis1_r;
        ctla_nxt = ctla_r;
        wr_hit_a = 1'b0;
        if (i_wr) begin
            unique case (i_addr)
                atg_pkg::OFS_CONTROL_B: begin
                    ctlb_nxt = i_wdata & atg_pkg::CTLB_WMASK;
                end
                atg_pkg::OFS_DISABLE_0: begin
                    dis0_nxt = i_wdata;
                end
                atg_pkg::OFS_DISABLE_1: begin
                    dis1_nxt = {i_wdata[7:4], 4'h0};
                end
                atg_pkg::OFS_CONTROL_A: begin
                    wr_hit_a = 1'b1;
                    ctla_nxt[atg_pkg::BIT_CONV_EN] = i_wdata[atg_pkg::BIT_CONV_EN];
                    ctla_nxt[atg_pkg::BIT_AUTO_EN] = i_wdata[atg_pkg::BIT_AUTO_EN];
                    // done flag clears by writing one
                    if (i_wdata[atg_pkg::BIT_DONE_FLAG]) begin
                        ctla_nxt[atg_pkg::BIT_DONE_FLAG] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // done sets after the clear so a simultaneous event is kept
        if (i_conv_done && busy_r) begin
            ctla_nxt[atg_pkg::BIT_DONE_FLAG] = 1'b1;
        end
        ctla_nxt[6] = 1'b0;
        ctla_nxt[3:0] = 4'h0;
    end

    // single start from software: bit 6 of control a written one together with enable bit 7
    assign sw_start = wr_hit_a && i_wdata[6] && i_wdata[atg_pkg::BIT_CONV_EN];

    // conversion sequencing and deferred channel msb
    always_comb begin
        busy_nxt     = busy_r;
        chan_msb_nxt = chan_msb_r;
        start_nxt    = 1'b0;
        if ((trig_start || sw_start) && !busy_r) begin
            start_nxt = 1'b1;
            busy_nxt  = 1'b1;
        end
        if (i_conv_done && busy_r) begin
            busy_nxt = 1'b0;
        end
        // msb follows the register only between conversions
        if (!busy_r || i_conv_done) begin
            chan_msb_nxt = ctlb_r[atg_pkg::BIT_CHAN_MSB];
        end
    end

    // core configuration and gain mapping
    always_comb begin
        cfg_nxt          = cfg_r;
        cfg_nxt.bipolar  = ctlb_r[atg_pkg::BIT_BIPOLAR];
        cfg_nxt.ref_high = ctlb_r[atg_pkg::BIT_REF_HIGH];
        cfg_nxt.chan_msb = chan_msb_r;
        // base codes: bit 1 = 20x family, bit 0 = 1x family
        if (i_gain_base[1]) begin
            cfg_nxt.gain = ctlb_r[atg_pkg::BIT_GAIN_ALT] ? atg_pkg::ATG_GAIN_32X
                                                         : atg_pkg::ATG_GAIN_20X;
        end else if (i_gain_base[0]) begin
            cfg_nxt.gain = ctlb_r[atg_pkg::BIT_GAIN_ALT] ? atg_pkg::ATG_GAIN_8X
                                                         : atg_pkg::ATG_GAIN_1X;
        end else begin
            cfg_nxt.gain = atg_pkg::ATG_GAIN_1X;
        end
    end

    // result shaping; the core flags i_raw_neg when positive input is not above negative
    always_comb begin
        result_nxt  = result_r;
        res_vld_nxt = 1'b0;
        if (i_conv_done && busy_r) begin
            res_vld_nxt = 1'b1;
            if (cfg_r.bipolar) begin
                // nine magnitude bits plus sign, two's complement
                result_nxt = i_raw_neg ? (10'h000 - {1'b0, i_raw_mag[8:0]})
                                       : {1'b0, i_raw_mag[8:0]};
            end else if (i_raw_neg) begin
                result_nxt = 10'h3FF;
            end else begin
                result_nxt = i_raw_mag;
            end
        end
    end

    // register reads, data stand one cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                atg_pkg::OFS_CONTROL_B:  rdata_nxt = ctlb_r & atg_pkg::CTLB_WMASK;
                atg_pkg::OFS_DISABLE_0:  rdata_nxt = dis0_r;
                atg_pkg::OFS_DISABLE_1:  rdata_nxt = dis1_r;
                atg_pkg::OFS_CONTROL_A:  rdata_nxt = {ctla_r[7], busy_r, ctla_r[5:0]};
                atg_pkg::OFS_MUX_STATUS: rdata_nxt = {7'h00, chan_msb_r};
                default:                 rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctlb_r     <= atg_pkg::RST_CONTROL_B;
            dis0_r     <= atg_pkg::RST_DISABLE_0;
            dis1_r     <= atg_pkg::RST_DISABLE_1;
            ctla_r     <= atg_pkg::RST_CONTROL_A;
            rdata_r    <= 8'h00;
            busy_r     <= 1'b0;
            chan_msb_r <= 1'b0;
            cfg_r      <= '0;
            result_r   <= 10'h000;
            res_vld_r  <= 1'b0;
            start_r    <= 1'b0;
        end else begin
            ctlb_r     <= ctlb_nxt;
            dis0_r     <= dis0_nxt;
            dis1_r     <= dis1_nxt;
            ctla_r     <= ctla_nxt;
            rdata_r    <= rdata_nxt;
            busy_r     <= busy_nxt;
            chan_msb_r <= chan_msb_nxt;
            cfg_r      <= cfg_nxt;
            result_r   <= result_nxt;
            res_vld_r  <= res_vld_nxt;
            start_r    <= start_nxt;
        end
    end

    assign o_rdata        = rdata_r;
    assign o_conv_start   = start_r;
    assign o_core_cfg     = cfg_r;
    assign o_result       = result_r;
    assign o_result_valid = res_vld_r;
    assign o_pin_rd       = pin_rd;
    assign o_buf_off      = buf_off;
    assign o_refpin_off   = dis0_r[atg_pkg::BIT_REFPIN_DIS];

endmodule : atg_ctrl

// *** rtl/atg_pkg.sv ***
// package: register map, field layout, trigger codes and carriers for the converter control block
//
// Summary of operation
// - gain stage is unipolar after reset; bipolar when bipolar_input_select bit 7 set.
// - unipolar with positive input not above negative saturates result to reference.
// - unipolar gives 10-bit result; bipolar gives two's complement 9 bits plus sign.
// - gain_alternate_select set turns 20x into 32x and 1x into 8x.
// - bit 5 of converter_control_b is read-only and reads zero.
// - reference_select_high picks internal 1.1 V or 2.56 V with other select bits.
// - channel_select_msb written mid-conversion takes effect when conversion completes.
// - auto_trigger_source acts only while auto_trigger_enable is one.
// - auto-trigger starts a conversion on each rising edge of the selected flag that comes while no conversion runs.
// - switching from clear source to set source is a rising edge; starts if enabled.
// - selecting free running (code 0) never itself makes a trigger event.
// - source codes 0..7: free, comparator, ext int 0, t0 A, t0 ovf, t0 B, t1 ovf, wdt.
// - analog_input_disable_0 bits 7:4 and 2:0 disable channel pins 6..0 buffers.
// - analog_input_disable_0 bit 3 disables the reference pin input buffer.
// - analog_input_disable_1 bits 7:4 disable channel pins 10..7 buffers.
// - while a disable bit is set, that pin's port readback reads zero.
package atg_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_DISABLE_0   = 8'h01;
    localparam logic [7:0] OFS_CONTROL_B   = 8'h03;
    localparam logic [7:0] OFS_DISABLE_1   = 8'h04;
    // control/status bits the table lacks (converter_control_a subset)
    localparam logic [7:0] OFS_CONTROL_A   = 8'h06;
    localparam logic [7:0] OFS_MUX_STATUS  = 8'h07;

    localparam logic [7:0] RST_DISABLE_0   = 8'h00;
    localparam logic [7:0] RST_CONTROL_B   = 8'h00;
    localparam logic [7:0] RST_DISABLE_1   = 8'h00;
    localparam logic [7:0] RST_CONTROL_A   = 8'h00;

    // converter_control_b fields
    localparam int unsigned BIT_BIPOLAR    = 7;
    localparam int unsigned BIT_GAIN_ALT   = 6;
    localparam int unsigned BIT_RESERVED   = 5;
    localparam int unsigned BIT_REF_HIGH   = 4;
    localparam int unsigned BIT_CHAN_MSB   = 3;
    localparam int unsigned TRIG_SRC_LSB   = 0;
    localparam logic [7:0]  CTLB_WMASK     = 8'hDF;

    // converter_control_a fields
    localparam int unsigned BIT_CONV_EN    = 7;
    localparam int unsigned BIT_AUTO_EN    = 5;
    localparam int unsigned BIT_DONE_FLAG  = 4;

    // analog_input_disable_0: bit 3 is the reference pin
    localparam int unsigned BIT_REFPIN_DIS = 3;
    localparam int unsigned PIN_COUNT      = 11;

    typedef enum logic [2:0] {
        ATG_SRC_FREE_RUN  = 3'h0,
        ATG_SRC_COMPARE   = 3'h1,
        ATG_SRC_EXT_INT0  = 3'h2,
        ATG_SRC_T0_CMP_A  = 3'h3,
        ATG_SRC_T0_OVF    = 3'h4,
        ATG_SRC_T0_CMP_B  = 3'h5,
        ATG_SRC_T1_OVF    = 3'h6,
        ATG_SRC_WATCHDOG  = 3'h7
    } atg_src_t;

    typedef enum logic [1:0] {
        ATG_GAIN_1X  = 2'h0,
        ATG_GAIN_8X  = 2'h1,
        ATG_GAIN_20X = 2'h2,
        ATG_GAIN_32X = 2'h3
    } atg_gain_t;

    // settings handed to the analog core
    typedef struct packed {
        logic      bipolar;
        logic      ref_high;
        logic      chan_msb;
        atg_gain_t gain;
    } atg_core_cfg_t;

    // register port
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } atg_bus_req_t;

endpackage : atg_pkg

// *** rtl/atg_trig_sel.sv ***
// trigger source multiplexer with rising-edge start detection
module atg_trig_sel #(
    parameter int unsigned SRC_N = 8
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // selection
    input  wire logic [2:0]       i_src,
    input  wire logic             i_auto_en,
    input  wire logic             i_conv_en,
    // trigger flags
    input  wire logic [SRC_N-1:0] i_flags,
    // start pulse
    output logic                  o_start
);

    logic sel_flag;
    logic sel_flag_r;
    logic start_r;
    logic start_nxt;

    always_comb begin
        // free running drives a constant low so selecting it cannot rise
        if (i_src == 3'h0) begin
            sel_flag = 1'b0;
        end else begin
            sel_flag = i_flags[i_src];
        end
        // prev register compares against whatever is now selected: a switch
        // from a clear to a set source rises here too
        start_nxt = i_auto_en && i_conv_en && sel_flag && !sel_flag_r;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sel_flag_r <= 1'b0;
            start_r    <= 1'b0;
        end else begin
            sel_flag_r <= sel_flag;
            start_r    <= start_nxt;
        end
    end

    assign o_start = start_r;

endmodule : atg_trig_sel

// *** rtl/atg_pin_gate.sv ***
// per-pin input buffer gating with synchronised readback
module atg_pin_gate #(
    parameter int unsigned PIN_N = 11
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // pins and disables
    input  wire logic [PIN_N-1:0] i_pin,
    input  wire logic [PIN_N-1:0] i_disable,
    // readback
    output logic      [PIN_N-1:0] o_pin_rd,
    output logic      [PIN_N-1:0] o_buf_off
);

    logic [PIN_N-1:0] s1_r;
    logic [PIN_N-1:0] s2_r;
    logic [PIN_N-1:0] s3_r;
    logic [PIN_N-1:0] val_r;
    logic [PIN_N-1:0] val_nxt;
    logic [PIN_N-1:0] rd_r;
    logic [PIN_N-1:0] rd_nxt;
    logic [PIN_N-1:0] off_r;

    genvar g;
    generate
        for (g = 0; g < PIN_N; g++) begin : g_pin
            always_comb begin
                // a change counts only once stages two and three agree
                val_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : val_r[g];
                rd_nxt[g]  = i_disable[g] ? 1'b0 : val_nxt[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            val_r <= '0;
            rd_r  <= '0;
            off_r <= '0;
        end else begin
            s1_r  <= i_pin & ~i_disable;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            val_r <= val_nxt;
            rd_r  <= rd_nxt;
            off_r <= i_disable;
        end
    end

    assign o_pin_rd  = rd_r;
    assign o_buf_off = off_r;

endmodule : atg_pin_gate

// *** tb/atg_ctrl_sva.sv ***
// assertion checker for the converter control block ports
module atg_ctrl_sva #(
    parameter int unsigned PIN_N = 11
) (
    // clock and reset
    input wire logic                       i_clk_sys,
    input wire logic                       i_rst,
    // register port
    input wire logic [atg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [atg_pkg::DATA_W-1:0] i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [atg_pkg::DATA_W-1:0] o_rdata,
    // converter core
    input wire logic                       i_conv_done,
    input wire logic [9:0]                 i_raw_mag,
    input wire logic                       i_raw_neg,
    input wire logic                       o_conv_start,
    input wire atg_pkg::atg_core_cfg_t     o_core_cfg,
    input wire logic [9:0]                 o_result,
    input wire logic                       o_result_valid,
    // pins
    input wire logic [PIN_N-1:0]           o_pin_rd,
    input wire logic [PIN_N-1:0]           o_buf_off,
    input wire logic                       o_refpin_off
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_start_one;
        o_conv_start |=> !o_conv_start;
    endproperty
    a_start_one: assert property (p_start_one) else $error("start pulse longer than one cycle");
    property p_rd_bit5;
        i_rd && i_addr == atg_pkg::OFS_CONTROL_B |=> o_rdata[5] == 1'b0;
    endproperty
    a_rd_bit5: assert property (p_rd_bit5) else $error("reserved control bit read as one");
    // one cycle of settling allowed after a disable is raised
    property p_pin_zero;
        (o_buf_off & $past(o_buf_off) & o_pin_rd) == '0;
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("disabled pin reads one");
    property p_low_off;
        logic [7:0] v;
        (i_wr && i_addr == atg_pkg::OFS_DISABLE_0, v = i_wdata)
            |-> ##2 o_buf_off[6:0] == {v[7:4], v[2:0]};
    endproperty
    a_low_off: assert property (p_low_off) else $error("low channel buffer disables wrong");
    property p_refpin;
        logic v;
        (i_wr && i_addr == atg_pkg::OFS_DISABLE_0, v = i_wdata[3]) |-> ##1 o_refpin_off == v;
    endproperty
    a_refpin: assert property (p_refpin) else $error("reference pin disable wrong");
    property p_high_off;
        logic [7:0] v;
        (i_wr && i_addr == atg_pkg::OFS_DISABLE_1, v = i_wdata) |-> ##2 o_buf_off[10:7] == v[7:4];
    endproperty
    a_high_off: assert property (p_high_off) else $error("high channel buffer disables wrong");
    property p_bipolar;
        logic b;
        (i_wr && i_addr == atg_pkg::OFS_CONTROL_B, b = i_wdata[7])
            |-> ##2 o_core_cfg.bipolar == b;
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("bipolar mode not applied");
    property p_saturate;
        i_conv_done && i_raw_neg && !o_core_cfg.bipolar
            |=> o_result_valid && o_result == 10'h3FF;
    endproperty
    a_saturate: assert property (p_saturate) else $error("unipolar result not saturated");
    property p_twos;
        logic [8:0] m;
        logic n;
        (i_conv_done && o_core_cfg.bipolar, m = i_raw_mag[8:0], n = i_raw_neg)
            |=> o_result_valid && o_result == (n ? (~{1'b0, m} + 10'h001) : {1'b0, m});
    endproperty
    a_twos: assert property (p_twos) else $error("bipolar result not two's complement");
endmodule : atg_ctrl_sva

bind atg_ctrl atg_ctrl_sva #(.PIN_N(PIN_N)) u_sva (.i_clk_sys, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_conv_done, .i_raw_mag, .i_raw_neg, .o_conv_start, .o_core_cfg,
    .o_result, .o_result_valid, .o_pin_rd, .o_buf_off, .o_refpin_off);

// *** tb/atg_core_model.sv ***
// behavioural converter core: answers each start with a done pulse and a raw sample
module atg_core_model (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // control
    input  wire logic i_slow,
    input  wire logic i_start,
    // conversion answer
    output logic       o_done,
    output logic [9:0] o_raw_mag,
    output logic       o_raw_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_r     <= 5'h00;
            o_done    <= 1'b0;
            o_raw_mag <= 10'h000;
            o_raw_neg <= 1'b0;
        end else begin
            o_done <= (cnt_r == 5'h01);
            if (i_start) begin
                cnt_r     <= i_slow ? 5'h0E : 5'h03;
                // top bit kept clear so the 9-bit bipolar magnitude is exact
                o_raw_mag <= {1'b0, 9'($urandom)};
                o_raw_neg <= 1'($urandom);
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end
        end
    end
endmodule : atg_core_model

// *** tb/atg_ctrl_tb.sv ***
// self-checking bench for the converter control block
module atg_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT_SLOW = 14;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_slow = 1'b0, rd_d = 1'b0;
    logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, i_trig_flags = 8'h00, o_rdata;
    logic [2:0]  i_gain_base = 3'h1;
    logic [10:0] i_pin = 11'h000, o_pin_rd, o_buf_off, mask;
    logic [9:0]  i_raw_mag, o_result;
    logic        i_conv_done, i_raw_neg, o_conv_start, o_result_valid, o_refpin_off;
    logic [7:0]  d0, d1, exp_q[$];
    atg_pkg::atg_core_cfg_t o_core_cfg;
    logic        bip = 1'b0;
    logic [9:0]  exp_r = 10'h000;
    int errors = 0, checked = 0, starts = 0;

    atg_ctrl dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_trig_flags,
        .i_conv_done, .i_raw_mag, .i_raw_neg, .i_gain_base, .o_conv_start, .o_core_cfg,
        .o_result, .o_result_valid, .i_pin, .o_pin_rd, .o_buf_off, .o_refpin_off);
    atg_core_model u_core (.i_clk_sys, .i_rst, .i_slow, .i_start(o_conv_start),
        .o_done(i_conv_done), .o_raw_mag(i_raw_mag), .o_raw_neg(i_raw_neg));

    initial forever #2.5 i_clk_sys = ~i_clk_sys;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("counts: checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        if (a == 8'h03) bip = d[7];
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask : rd

    // raise one flag and count the starts until the conversion is surely over
    task automatic trig(input int src, input int exp_n);
        int s0;
        @(posedge i_clk_sys);
        s0 = starts;
        i_trig_flags[src] <= 1'b1;
        repeat (LAT_SLOW + 6) @(posedge i_clk_sys);
        chk(16'(starts - s0), 16'(exp_n));
        i_trig_flags <= 8'h00;
    endtask : trig

    // read data stand only in the cycle after the strobe, so sample them exactly there
    always @(posedge i_clk_sys) begin
        if (rd_d) chk(o_rdata, exp_q.pop_front());
        rd_d = i_rd;
        if (o_conv_start === 1'b1) starts++;
        // result stands the cycle after done; expectation follows the mode last written
        if (o_result_valid === 1'b1) chk(o_result, exp_r);
        if (i_conv_done === 1'b1) begin
            if (!i_raw_neg) exp_r = i_raw_mag;
            else if (bip) exp_r = ~{1'b0, i_raw_mag[8:0]} + 10'h001;
            else exp_r = 10'h3FF;
        end
    end

    initial begin
        repeat (5000) @(posedge i_clk_sys);
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hB555));
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(8'h01, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'hDF);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hF0);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            i_pin <= 11'($urandom);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            wr(8'h01, d0);
            wr(8'h04, d1);
            repeat (6) @(posedge i_clk_sys);
            mask = {d1[7:4], d0[7:4], d0[2:0]};
            chk(o_buf_off, mask);
            chk(o_pin_rd, i_pin & ~mask);
            chk(o_refpin_off, d0[3]);
        end
        $display("test pins done");
        for (int g = 0; g < 4; g++) begin
            i_gain_base <= g[1] ? 3'h2 : 3'h1;
            wr(8'h03, {1'b0, g[0], 1'b0, g[0], 4'h0});
            repeat (3) @(posedge i_clk_sys);
            chk(o_core_cfg.gain, g[1] ? (g[0] ? atg_pkg::ATG_GAIN_32X : atg_pkg::ATG_GAIN_20X)
                : (g[0] ? atg_pkg::ATG_GAIN_8X : atg_pkg::ATG_GAIN_1X));
            chk(o_core_cfg.ref_high, g[0]);
        end
        $display("test gain done");
        wr(8'h06, 8'h80);
        wr(8'h03, 8'h03);
        trig(3, 0);
        wr(8'h06, 8'hA0);
        for (int s = 1; s < 8; s++) begin
            i_slow <= s[0];
            wr(8'h03, {s[0], 4'h0, 3'(s)});
            trig(s, 1);
        end
        wr(8'h03, 8'h00);
        trig(0, 0);
        wr(8'h03, 8'h01);
        i_trig_flags <= 8'h04;
        d0 = 8'(starts);
        wr(8'h03, 8'h02);
        repeat (4) @(posedge i_clk_sys);
        chk(8'(starts) - d0, 8'h01);
        wr(8'h03, 8'h0A);
        repeat (2) @(posedge i_clk_sys);
        chk(o_core_cfg.chan_msb, 1'b0);
        repeat (LAT_SLOW + 4) @(posedge i_clk_sys);
        chk(o_core_cfg.chan_msb, 1'b1);
        rd(8'h07, 8'h01);
        i_trig_flags <= 8'h00;
        repeat (3) @(posedge i_clk_sys);
        // software start, then done flag set by the conversion and cleared by writing one
        d0 = 8'(starts);
        wr(8'h06, 8'hD0);
        repeat (LAT_SLOW + 6) @(posedge i_clk_sys);
        chk(8'(starts) - d0, 8'h01);
        rd(8'h06, 8'h90);
        wr(8'h06, 8'h90);
        rd(8'h06, 8'h80);
        $display("test triggers done");
        tally_and_finish();
    end
endmodule : atg_ctrl_tb
